// ==== rtl/gpio_defines.svh ====
// Register offsets, field positions and reset values of the I/O block.
// Assumes an 8-bit register bus with a 5-bit register address.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

`define GPIO_ADDR_W          5
`define GPIO_OFS_PORT_A      5'h00
`define GPIO_OFS_PORT_B      5'h01
`define GPIO_OFS_PORT_C      5'h02
`define GPIO_OFS_FUNC_A      5'h03
`define GPIO_OFS_FUNC_B      5'h04
`define GPIO_OFS_FUNC_C      5'h05
`define GPIO_OFS_DIR_A       5'h06
`define GPIO_OFS_DIR_B       5'h07
`define GPIO_OFS_DIR_C       5'h08
`define GPIO_OFS_PULLDIS_A   5'h09
`define GPIO_OFS_PULLDIS_B   5'h0A
`define GPIO_OFS_PULLDIS_C   5'h0B
`define GPIO_OFS_PULLDOWN    5'h0C
`define GPIO_OFS_EDGE        5'h0D
`define GPIO_OFS_SUBEN       5'h0E
`define GPIO_OFS_PINEN_B     5'h0F
`define GPIO_OFS_FLAGS_A     5'h10
`define GPIO_OFS_FLAGS_B     5'h11
`define GPIO_OFS_FLAGS_C     5'h12
`define GPIO_OFS_CPU_EN      5'h13
`define GPIO_OFS_CPU_FLAG    5'h14

// Bit positions shared by the per-port control registers.
`define GPIO_BIT_PORT_A      0
`define GPIO_BIT_PORT_B      1
`define GPIO_BIT_PORT_C      2
// Bit positions in the sub-port enable register.
`define GPIO_BIT_A_LO_EN     0
`define GPIO_BIT_A_HI_EN     1
`define GPIO_BIT_C_EN        2

`define GPIO_RST_ZERO8       8'h00
`define GPIO_RST_ZERO5       5'h00
`define GPIO_RST_ZERO3       3'h0
// Port B pins 0 and 1 are the high-drive pins without pull resistors.
`define GPIO_NO_PULL_B       8'h03

`endif

// ==== rtl/gpio_pkg.sv ====
// Types shared by the general-purpose I/O block.
// Assumes the power controller reports its mode with this enumeration.
`default_nettype none
package gpio_pkg;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_IDLE, PWR_DEEP2, PWR_DEEP3} power_mode_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ==== rtl/gpio_edge_detect.sv ====
// Per-pin edge detector for one port.
// Assumes pin levels are already synchronous to core_clk.
`default_nettype none
module gpio_edge_detect
#(
  parameter int W = 8
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinLevel,
  input  wire logic [W-1:0] pinArmed,
  input  wire logic         fallingEdge,
  output logic      [W-1:0] pinEvent
);

  logic primed_q;

  // The first sample after reset is only a reference, so a high pin is no edge.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      primed_q <= 1'b0;
    else
      primed_q <= 1'b1;
  end

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic prev_q;
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        prev_q <= 1'b0;
      else
        prev_q <= pinLevel[i];
    end
    assign pinEvent[i] = primed_q & pinArmed[i] &
                         (fallingEdge ? (prev_q & ~pinLevel[i]) : (~prev_q & pinLevel[i]));
  end

endmodule
`default_nettype wire

// ==== rtl/gpio_pad_ctrl.sv ====
// Registered pad drive, enable and pull control for one port.
// Assumes the pad cell pulls when asked and drives when its enable is low.
`default_nettype none
module gpio_pad_ctrl
#(
  parameter int         W       = 8,
  parameter logic [W-1:0] NO_PULL = '0
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         hold,
  input  wire logic [W-1:0] funcSel,
  input  wire logic [W-1:0] dirSel,
  input  wire logic [W-1:0] outLatch,
  input  wire logic [W-1:0] periphOut,
  input  wire logic [W-1:0] periphOe,
  input  wire logic [W-1:0] pullDis,
  input  wire logic         pullDownSel,
  output logic      [W-1:0] padOut,
  output logic      [W-1:0] padOeN,
  output logic      [W-1:0] padPullUp,
  output logic      [W-1:0] padPullDown
);

  for (genvar i = 0; i < W; i++)
  begin : g_pin
    logic drive;
    logic pulled;
    assign drive  = funcSel[i] ? periphOe[i] : dirSel[i];
    assign pulled = ~drive & ~pullDis[i] & ~NO_PULL[i];

    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        padOut[i]      <= 1'b0;
        padOeN[i]      <= 1'b1;
        padPullUp[i]   <= ~NO_PULL[i];
        padPullDown[i] <= 1'b0;
      end
      else if (!hold)
      begin
        padOut[i]      <= funcSel[i] ? periphOut[i] : outLatch[i];
        padOeN[i]      <= ~drive;
        padPullUp[i]   <= pulled & ~pullDownSel;
        padPullDown[i] <= pulled & pullDownSel;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/gpio_ports.sv ====
// Three I/O ports with per-pin edge flags and port-level interrupt requests.
// Assumes a single-cycle register bus, synchronous pad inputs and an external power controller.
`include "gpio_defines.svh"
`default_nettype none

// How it works
// - Port A and B are eight pins wide, port C five; each readable per bit or byte.
// - Reading a port register returns the pin levels, whatever the pin configuration.
// - A read flagged as read-modify-write returns the output latch instead of pins.
// - Function select bit picks general-purpose or peripheral use per pin.
// - After reset every pin is a general-purpose input.
// - After reset inputs have pull-up enabled, except port B pins zero and one.
// - Direction bit can change anytime; one makes an output, zero an input.
// - Inputs pull up, pull down or float; pull disable bit one floats it.
// - Port B pins zero and one never get any pull.
// - In the two deepest power modes pads hold their drive, function and value.
// - General-purpose inputs detect a rising or falling edge, selectable per port.
// - An enabled pin edge raises a wake request when its port's CPU-level enable is set.
// - Each port has one CPU-level interrupt enable common to its pins.
// - Each port B pin also has its own enable.
// - Port A has separate enables for its low and high nibble.
// - Port C pins share one enable.
// - A detected edge sets that pin's status flag.
// - The status flag sets even when the pin's enable is off.
// - Writing zero to a status flag clears it.
module gpio_ports
  import gpio_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic [`GPIO_ADDR_W-1:0] busAddr,
  input  wire logic [7:0]              busWdata,
  input  wire logic                    busWr,
  input  wire logic                    busRd,
  input  wire logic                    busRmw,
  output logic      [7:0]              busRdata,
  input  wire power_mode_t             powerMode,
  input  wire logic [7:0]              padAIn,
  input  wire logic [7:0]              padBIn,
  input  wire logic [4:0]              padCIn,
  output logic      [7:0]              padAOut,
  output logic      [7:0]              padAOeN,
  output logic      [7:0]              padAPullUp,
  output logic      [7:0]              padAPullDown,
  output logic      [7:0]              padBOut,
  output logic      [7:0]              padBOeN,
  output logic      [7:0]              padBPullUp,
  output logic      [7:0]              padBPullDown,
  output logic      [4:0]              padCOut,
  output logic      [4:0]              padCOeN,
  output logic      [4:0]              padCPullUp,
  output logic      [4:0]              padCPullDown,
  input  wire logic [7:0]              periphAOut,
  input  wire logic [7:0]              periphAOe,
  input  wire logic [7:0]              periphBOut,
  input  wire logic [7:0]              periphBOe,
  input  wire logic [4:0]              periphCOut,
  input  wire logic [4:0]              periphCOe,
  output logic      [7:0]              periphAIn,
  output logic      [7:0]              periphBIn,
  output logic      [4:0]              periphCIn,
  output logic                         irqPortA,
  output logic                         irqPortB,
  output logic                         irqPortC,
  output logic                         wakeReq
);

  byte_t      portAOut_q;
  byte_t      portBOut_q;
  logic [4:0] portCOut_q;
  byte_t      funcSelA_q;
  byte_t      funcSelB_q;
  logic [4:0] funcSelC_q;
  byte_t      dirSelA_q;
  byte_t      dirSelB_q;
  logic [4:0] dirSelC_q;
  byte_t      pullDisA_q;
  byte_t      pullDisB_q;
  logic [4:0] pullDisC_q;
  logic [2:0] pullDownSel_q;
  logic [2:0] fallingEdge_q;
  logic [2:0] subEnable_q;
  byte_t      portBPinEnable_q;
  byte_t      portAPinFlags_q;
  byte_t      portBPinFlags_q;
  logic [4:0] portCPinFlags_q;
  logic [2:0] cpuIrqEnable_q;
  logic [2:0] cpuPortIrqFlag_q;
  byte_t      rdata_d;
  byte_t      eventA;
  byte_t      eventB;
  logic [4:0] eventC;
  byte_t      enableA;
  logic [4:0] enableC;
  logic [2:0] portHit;
  logic       deepSleep;

  function automatic logic wrAt(input logic [`GPIO_ADDR_W-1:0] ofs);
    wrAt = busWr && (busAddr == ofs);
  endfunction

  assign deepSleep = (powerMode == PWR_DEEP2) || (powerMode == PWR_DEEP3);
  assign enableA   = {{4{subEnable_q[`GPIO_BIT_A_HI_EN]}}, {4{subEnable_q[`GPIO_BIT_A_LO_EN]}}};
  assign enableC   = {5{subEnable_q[`GPIO_BIT_C_EN]}};

  // Output latches, writable as whole bytes; bit updates come as read-modify-write.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      portAOut_q <= `GPIO_RST_ZERO8;
      portBOut_q <= `GPIO_RST_ZERO8;
      portCOut_q <= `GPIO_RST_ZERO5;
    end
    else
    begin
      if (wrAt(`GPIO_OFS_PORT_A))
        portAOut_q <= busWdata;
      if (wrAt(`GPIO_OFS_PORT_B))
        portBOut_q <= busWdata;
      if (wrAt(`GPIO_OFS_PORT_C))
        portCOut_q <= busWdata[4:0];
    end
  end

  // Pad configuration; deep-sleep writes are stored, pads stay frozen.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      funcSelA_q    <= `GPIO_RST_ZERO8;
      funcSelB_q    <= `GPIO_RST_ZERO8;
      funcSelC_q    <= `GPIO_RST_ZERO5;
      dirSelA_q     <= `GPIO_RST_ZERO8;
      dirSelB_q     <= `GPIO_RST_ZERO8;
      dirSelC_q     <= `GPIO_RST_ZERO5;
      pullDisA_q    <= `GPIO_RST_ZERO8;
      pullDisB_q    <= `GPIO_RST_ZERO8;
      pullDisC_q    <= `GPIO_RST_ZERO5;
      pullDownSel_q <= `GPIO_RST_ZERO3;
    end
    else
    begin
      if (wrAt(`GPIO_OFS_FUNC_A))
        funcSelA_q <= busWdata;
      if (wrAt(`GPIO_OFS_FUNC_B))
        funcSelB_q <= busWdata;
      if (wrAt(`GPIO_OFS_FUNC_C))
        funcSelC_q <= busWdata[4:0];
      if (wrAt(`GPIO_OFS_DIR_A))
        dirSelA_q <= busWdata;
      if (wrAt(`GPIO_OFS_DIR_B))
        dirSelB_q <= busWdata;
      if (wrAt(`GPIO_OFS_DIR_C))
        dirSelC_q <= busWdata[4:0];
      if (wrAt(`GPIO_OFS_PULLDIS_A))
        pullDisA_q <= busWdata;
      if (wrAt(`GPIO_OFS_PULLDIS_B))
        pullDisB_q <= busWdata;
      if (wrAt(`GPIO_OFS_PULLDIS_C))
        pullDisC_q <= busWdata[4:0];
      if (wrAt(`GPIO_OFS_PULLDOWN))
        pullDownSel_q <= busWdata[2:0];
    end
  end

  // Interrupt configuration.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fallingEdge_q    <= `GPIO_RST_ZERO3;
      subEnable_q      <= `GPIO_RST_ZERO3;
      portBPinEnable_q <= `GPIO_RST_ZERO8;
      cpuIrqEnable_q   <= `GPIO_RST_ZERO3;
    end
    else
    begin
      if (wrAt(`GPIO_OFS_EDGE))
        fallingEdge_q <= busWdata[2:0];
      if (wrAt(`GPIO_OFS_SUBEN))
        subEnable_q <= busWdata[2:0];
      if (wrAt(`GPIO_OFS_PINEN_B))
        portBPinEnable_q <= busWdata;
      if (wrAt(`GPIO_OFS_CPU_EN))
        cpuIrqEnable_q <= busWdata[2:0];
    end
  end

  // Only general-purpose inputs are armed for edge detection.
  gpio_edge_detect #(.W(8)) u_edgeA
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .pinLevel    (padAIn),
    .pinArmed    (~funcSelA_q & ~dirSelA_q),
    .fallingEdge (fallingEdge_q[`GPIO_BIT_PORT_A]),
    .pinEvent    (eventA)
  );

  gpio_edge_detect #(.W(8)) u_edgeB
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .pinLevel    (padBIn),
    .pinArmed    (~funcSelB_q & ~dirSelB_q),
    .fallingEdge (fallingEdge_q[`GPIO_BIT_PORT_B]),
    .pinEvent    (eventB)
  );

  gpio_edge_detect #(.W(5)) u_edgeC
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .pinLevel    (padCIn),
    .pinArmed    (~funcSelC_q & ~dirSelC_q),
    .fallingEdge (fallingEdge_q[`GPIO_BIT_PORT_C]),
    .pinEvent    (eventC)
  );

  // A new edge wins over a clearing write, so no event is lost.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      portAPinFlags_q <= `GPIO_RST_ZERO8;
      portBPinFlags_q <= `GPIO_RST_ZERO8;
      portCPinFlags_q <= `GPIO_RST_ZERO5;
    end
    else
    begin
      portAPinFlags_q <= (portAPinFlags_q & (wrAt(`GPIO_OFS_FLAGS_A) ? busWdata : 8'hFF)) | eventA;
      portBPinFlags_q <= (portBPinFlags_q & (wrAt(`GPIO_OFS_FLAGS_B) ? busWdata : 8'hFF)) | eventB;
      portCPinFlags_q <= (portCPinFlags_q & (wrAt(`GPIO_OFS_FLAGS_C) ? busWdata[4:0] : 5'h1F)) | eventC;
    end
  end

  assign portHit[`GPIO_BIT_PORT_A] = |(eventA & enableA);
  assign portHit[`GPIO_BIT_PORT_B] = |(eventB & portBPinEnable_q);
  assign portHit[`GPIO_BIT_PORT_C] = |(eventC & enableC);

  // Software clears the CPU port flag after the pin flags.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cpuPortIrqFlag_q <= `GPIO_RST_ZERO3;
    else
      cpuPortIrqFlag_q <= (cpuPortIrqFlag_q & (wrAt(`GPIO_OFS_CPU_FLAG) ? busWdata[2:0] : 3'h7)) | portHit;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irqPortA <= 1'b0;
      irqPortB <= 1'b0;
      irqPortC <= 1'b0;
      wakeReq  <= 1'b0;
    end
    else
    begin
      irqPortA <= cpuPortIrqFlag_q[`GPIO_BIT_PORT_A] & cpuIrqEnable_q[`GPIO_BIT_PORT_A];
      irqPortB <= cpuPortIrqFlag_q[`GPIO_BIT_PORT_B] & cpuIrqEnable_q[`GPIO_BIT_PORT_B];
      irqPortC <= cpuPortIrqFlag_q[`GPIO_BIT_PORT_C] & cpuIrqEnable_q[`GPIO_BIT_PORT_C];
      wakeReq  <= |(portHit & cpuIrqEnable_q);
    end
  end

  gpio_pad_ctrl #(.W(8), .NO_PULL(8'h00)) u_padA
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .hold        (deepSleep),
    .funcSel     (funcSelA_q),
    .dirSel      (dirSelA_q),
    .outLatch    (portAOut_q),
    .periphOut   (periphAOut),
    .periphOe    (periphAOe),
    .pullDis     (pullDisA_q),
    .pullDownSel (pullDownSel_q[`GPIO_BIT_PORT_A]),
    .padOut      (padAOut),
    .padOeN      (padAOeN),
    .padPullUp   (padAPullUp),
    .padPullDown (padAPullDown)
  );

  gpio_pad_ctrl #(.W(8), .NO_PULL(`GPIO_NO_PULL_B)) u_padB
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .hold        (deepSleep),
    .funcSel     (funcSelB_q),
    .dirSel      (dirSelB_q),
    .outLatch    (portBOut_q),
    .periphOut   (periphBOut),
    .periphOe    (periphBOe),
    .pullDis     (pullDisB_q),
    .pullDownSel (pullDownSel_q[`GPIO_BIT_PORT_B]),
    .padOut      (padBOut),
    .padOeN      (padBOeN),
    .padPullUp   (padBPullUp),
    .padPullDown (padBPullDown)
  );

  gpio_pad_ctrl #(.W(5), .NO_PULL(5'h00)) u_padC
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .hold        (deepSleep),
    .funcSel     (funcSelC_q),
    .dirSel      (dirSelC_q),
    .outLatch    (portCOut_q),
    .periphOut   (periphCOut),
    .periphOe    (periphCOe),
    .pullDis     (pullDisC_q),
    .pullDownSel (pullDownSel_q[`GPIO_BIT_PORT_C]),
    .padOut      (padCOut),
    .padOeN      (padCOeN),
    .padPullUp   (padCPullUp),
    .padPullDown (padCPullDown)
  );

  // Peripherals see the pin levels one cycle late, which keeps every output registered.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      periphAIn <= `GPIO_RST_ZERO8;
      periphBIn <= `GPIO_RST_ZERO8;
      periphCIn <= `GPIO_RST_ZERO5;
    end
    else
    begin
      periphAIn <= padAIn;
      periphBIn <= padBIn;
      periphCIn <= padCIn;
    end
  end

  always_comb
  begin
    rdata_d = `GPIO_RST_ZERO8;
    case (busAddr)
      `GPIO_OFS_PORT_A:    rdata_d = busRmw ? portAOut_q : padAIn;
      `GPIO_OFS_PORT_B:    rdata_d = busRmw ? portBOut_q : padBIn;
      `GPIO_OFS_PORT_C:    rdata_d = {3'h0, busRmw ? portCOut_q : padCIn};
      `GPIO_OFS_FUNC_A:    rdata_d = funcSelA_q;
      `GPIO_OFS_FUNC_B:    rdata_d = funcSelB_q;
      `GPIO_OFS_FUNC_C:    rdata_d = {3'h0, funcSelC_q};
      `GPIO_OFS_DIR_A:     rdata_d = dirSelA_q;
      `GPIO_OFS_DIR_B:     rdata_d = dirSelB_q;
      `GPIO_OFS_DIR_C:     rdata_d = {3'h0, dirSelC_q};
      `GPIO_OFS_PULLDIS_A: rdata_d = pullDisA_q;
      `GPIO_OFS_PULLDIS_B: rdata_d = pullDisB_q;
      `GPIO_OFS_PULLDIS_C: rdata_d = {3'h0, pullDisC_q};
      `GPIO_OFS_PULLDOWN:  rdata_d = {5'h00, pullDownSel_q};
      `GPIO_OFS_EDGE:      rdata_d = {5'h00, fallingEdge_q};
      `GPIO_OFS_SUBEN:     rdata_d = {5'h00, subEnable_q};
      `GPIO_OFS_PINEN_B:   rdata_d = portBPinEnable_q;
      `GPIO_OFS_FLAGS_A:   rdata_d = portAPinFlags_q;
      `GPIO_OFS_FLAGS_B:   rdata_d = portBPinFlags_q;
      `GPIO_OFS_FLAGS_C:   rdata_d = {3'h0, portCPinFlags_q};
      `GPIO_OFS_CPU_EN:    rdata_d = {5'h00, cpuIrqEnable_q};
      `GPIO_OFS_CPU_FLAG:  rdata_d = {5'h00, cpuPortIrqFlag_q};
      default:             rdata_d = `GPIO_RST_ZERO8;
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busRdata <= `GPIO_RST_ZERO8;
    else
      busRdata <= busRd ? rdata_d : `GPIO_RST_ZERO8;
  end

endmodule
`default_nettype wire

// ==== tb/gpio_ports_sva.sv ====
// Concurrent checks on the I/O block's ports, attached by bind.
// Assumes one clock, an active-high reset and a single-cycle register bus.
`include "gpio_defines.svh"
`default_nettype none
module gpio_ports_sva
  import gpio_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [4:0]  busAddr,
  input wire logic [7:0]  busWdata,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic [7:0]  busRdata,
  input wire power_mode_t powerMode,
  input wire logic [7:0]  padBIn,
  input wire logic [7:0]  padAOut,
  input wire logic [7:0]  padAOeN,
  input wire logic [7:0]  padAPullUp,
  input wire logic [7:0]  padBPullUp,
  input wire logic [7:0]  padBPullDown,
  input wire logic        irqPortB,
  input wire logic        wakeReq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] funcA_q;
  logic [2:0] cpuEn_q;
  logic       deep;
  assign deep = (powerMode == PWR_DEEP2) || (powerMode == PWR_DEEP3);
  // Shadows of two control registers for the direction-to-pad and interrupt-gate checks.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      funcA_q <= 8'h00;
      cpuEn_q <= 3'h0;
    end
    else if (busWr)
    begin
      if (busAddr == `GPIO_OFS_FUNC_A)
        funcA_q <= busWdata;
      if (busAddr == `GPIO_OFS_CPU_EN)
        cpuEn_q <= busWdata[2:0];
    end
  end
  property p_reset_pads;
    $fell(rst) |-> padAOeN == 8'hFF && padAPullUp == 8'hFF;
  endproperty
  a_reset_pads: assert property (p_reset_pads)
    else $error("pads are not pulled-up inputs after reset");
  property p_no_pull;
    padBPullUp[1:0] == 2'h0 && padBPullDown[1:0] == 2'h0;
  endproperty
  a_no_pull: assert property (p_no_pull)
    else $error("high-drive pin has a pull enabled");
  property p_rdata_idle;
    !$past(busRd) |-> busRdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");
  property p_deep_hold;
    deep && $past(deep) |-> $stable(padAOut) && $stable(padAOeN);
  endproperty
  a_deep_hold: assert property (p_deep_hold)
    else $error("pad changed in deep sleep");
  property p_irq_cause;
    $rose(irqPortB) |-> $past(busWr, 2) || $past(padBIn, 2) != $past(padBIn, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("port interrupt rose without a pin edge or write");
  property p_dir_drive;
    busWr && busAddr == `GPIO_OFS_DIR_A && funcA_q == 8'h00 && !deep ##1 !deep
      |=> padAOeN == ~$past(busWdata, 2);
  endproperty
  a_dir_drive: assert property (p_dir_drive)
    else $error("direction write did not reach the pad enables");
  property p_irq_gate;
    !$past(cpuEn_q[1]) |-> !irqPortB;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("port interrupt raised while disabled");
  property p_wake_gate;
    wakeReq |-> $past(cpuEn_q) != 3'h0 || $past(cpuEn_q, 2) != 3'h0;
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("wake request with all port enables off");
  c_deep: cover property (deep && $past(deep));
  c_wake: cover property (wakeReq);
  c_irq: cover property ($rose(irqPortB));
endmodule
bind gpio_ports gpio_ports_sva u_sva (.core_clk, .rst, .busAddr, .busWdata, .busWr, .busRd, .busRdata,
  .powerMode, .padBIn, .padAOut, .padAOeN, .padAPullUp, .padBPullUp, .padBPullDown, .irqPortB, .wakeReq);
`default_nettype wire

// ==== tb/pin_model.sv ====
// External devices on one port; undriven pins follow the pad.
// Assumes the pad output enable is active low and pulls are active high.
`default_nettype none
module pin_model
#(
  parameter int W = 8
)
(
  input  wire logic         core_clk,
  input  wire logic [W-1:0] padOut,
  input  wire logic [W-1:0] padOeN,
  input  wire logic [W-1:0] padPullUp,
  input  wire logic [W-1:0] padPullDown,
  input  wire logic [W-1:0] extVal,
  input  wire logic [W-1:0] extDrive,
  output logic      [W-1:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle_q = 1'b0;
  // A floating pin toggles, so no check can pass on an arbitrary level.
  always_ff @(posedge core_clk)
    toggle_q <= ~toggle_q;
  always_comb
    for (int i = 0; i < W; i++)
      pinLevel[i] = !padOeN[i] ? padOut[i] : extDrive[i] ? extVal[i] :
                    padPullUp[i] ? 1'b1 : padPullDown[i] ? 1'b0 : toggle_q;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the I/O block with pin models on all ports.
// Assumes the register map of the defines header.
`include "gpio_defines.svh"
`default_nettype none
module tb_top
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst = 1'b1, busWr = 1'b0, busRd = 1'b0, busRmw = 1'b0, wakeSeen = 1'b0;
  logic [4:0]  busAddr = 5'h00, extC = 5'h00, periphCOut = 5'h00, periphCOe = 5'h00;
  logic [7:0]  busWdata = 8'h00, extA = 8'h00, extB = 8'h00, periphAOut = 8'h00, periphAOe = 8'h00;
  logic [7:0]  periphBOut = 8'h00, periphBOe = 8'h00, extDrvA = 8'hFF;
  power_mode_t powerMode = PWR_ACTIVE;
  logic [7:0]  busRdata, padAIn, padBIn, padAOut, padAOeN, padAPullUp, padAPullDown, periphAIn;
  logic [7:0]  padBOut, padBOeN, padBPullUp, padBPullDown, periphBIn;
  logic [4:0]  padCIn, padCOut, padCOeN, padCPullUp, padCPullDown, periphCIn;
  logic        irqPortA, irqPortB, irqPortC, wakeReq;
  int          numErrors = 0, checkCount = 0;
  always #20 core_clk = ~core_clk;
  gpio_ports dut (.core_clk, .rst, .busAddr, .busWdata, .busWr, .busRd, .busRmw, .busRdata, .powerMode,
    .padAIn, .padBIn, .padCIn, .padAOut, .padAOeN, .padAPullUp, .padAPullDown, .padBOut, .padBOeN,
    .padBPullUp, .padBPullDown, .padCOut, .padCOeN, .padCPullUp, .padCPullDown, .periphAOut, .periphAOe,
    .periphBOut, .periphBOe, .periphCOut, .periphCOe, .periphAIn, .periphBIn, .periphCIn, .irqPortA,
    .irqPortB, .irqPortC, .wakeReq);
  pin_model #(.W(8)) pinsA (.core_clk, .padOut(padAOut), .padOeN(padAOeN), .padPullUp(padAPullUp),
    .padPullDown(padAPullDown), .extVal(extA), .extDrive(extDrvA), .pinLevel(padAIn));
  pin_model #(.W(8)) pinsB (.core_clk, .padOut(padBOut), .padOeN(padBOeN), .padPullUp(padBPullUp),
    .padPullDown(padBPullDown), .extVal(extB), .extDrive(8'hFF), .pinLevel(padBIn));
  pin_model #(.W(5)) pinsC (.core_clk, .padOut(padCOut), .padOeN(padCOeN), .padPullUp(padCPullUp),
    .padPullDown(padCPullDown), .extVal(extC), .extDrive(5'h1F), .pinLevel(padCIn));
  // Wake is a one-cycle pulse, so it is latched here.
  always @(posedge core_clk)
    if (wakeReq === 1'b1)
      wakeSeen <= 1'b1;
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge core_clk);
    busWr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic m, input logic [7:0] e);
    @(posedge core_clk);
    busAddr <= a;
    busRmw <= m;
    busRd <= 1'b1;
    @(posedge core_clk);
    busRd <= 1'b0;
    busRmw <= 1'b0;
    #1 chk(busRdata, e);
  endtask
  initial
  begin
    repeat (4000) @(posedge core_clk);
    chk(8'h00, 8'h01);
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    idle(1);
    chk(padAOeN, 8'hFF);
    chk(padAPullUp, 8'hFF);
    chk(padBPullUp, 8'hFC);
    chk({3'h0, padCPullUp}, 8'h1F);
    rd(`GPIO_OFS_FUNC_A, 1'b0, 8'h00);
    rd(`GPIO_OFS_DIR_B, 1'b0, 8'h00);
    rd(5'h1F, 1'b0, 8'h00);
    $display("reset test done");
    @(posedge core_clk);
    extA <= 8'h5A;
    extC <= 5'h1F;
    rd(`GPIO_OFS_PORT_A, 1'b0, 8'h5A);
    rd(`GPIO_OFS_PORT_C, 1'b0, 8'h1F);
    rd(`GPIO_OFS_FLAGS_A, 1'b0, 8'h5A);
    rd(`GPIO_OFS_FLAGS_C, 1'b0, 8'h1F);
    rd(`GPIO_OFS_CPU_FLAG, 1'b0, 8'h00);
    wr(`GPIO_OFS_FLAGS_A, 8'hFF);
    rd(`GPIO_OFS_FLAGS_A, 1'b0, 8'h5A);
    wr(`GPIO_OFS_FLAGS_A, 8'hF0);
    rd(`GPIO_OFS_FLAGS_A, 1'b0, 8'h50);
    wr(`GPIO_OFS_FLAGS_A, 8'h00);
    wr(`GPIO_OFS_FLAGS_C, 8'h00);
    $display("pin read and flag test done");
    wr(`GPIO_OFS_PORT_A, 8'h3C);
    rd(`GPIO_OFS_PORT_A, 1'b1, 8'h3C);
    rd(`GPIO_OFS_PORT_A, 1'b0, 8'h5A);
    wr(`GPIO_OFS_DIR_A, 8'hFF);
    idle(2);
    chk(padAOeN, 8'h00);
    rd(`GPIO_OFS_PORT_A, 1'b0, 8'h3C);
    rd(`GPIO_OFS_FLAGS_A, 1'b0, 8'h00);
    @(posedge core_clk);
    periphAOut <= 8'hC3;
    periphAOe <= 8'hFF;
    wr(`GPIO_OFS_FUNC_A, 8'hFF);
    idle(2);
    chk(padAOut, 8'hC3);
    chk(padAOeN, 8'h00);
    wr(`GPIO_OFS_FUNC_A, 8'h00);
    wr(`GPIO_OFS_DIR_A, 8'h00);
    idle(3);
    wr(`GPIO_OFS_FLAGS_A, 8'h00);
    $display("output and function test done");
    extDrvA <= 8'h00;
    rd(`GPIO_OFS_PORT_A, 1'b0, 8'hFF);
    wr(`GPIO_OFS_PULLDIS_A, 8'hFF);
    idle(2);
    chk(padAPullUp, 8'h00);
    wr(`GPIO_OFS_PULLDIS_A, 8'h00);
    wr(`GPIO_OFS_PULLDOWN, 8'h03);
    idle(2);
    chk(padAPullDown, 8'hFF);
    chk(padAPullUp, 8'h00);
    chk(padBPullDown, 8'hFC);
    wr(`GPIO_OFS_PULLDOWN, 8'h00);
    extDrvA <= 8'hFF;
    $display("pull test done");
    wr(`GPIO_OFS_SUBEN, 8'h01);
    wr(`GPIO_OFS_CPU_EN, 8'h07);
    wr(`GPIO_OFS_PINEN_B, 8'h04);
    extA <= 8'h5B;
    idle(3);
    chk({7'h00, irqPortA}, 8'h01);
    chk({7'h00, wakeSeen}, 8'h01);
    wr(`GPIO_OFS_FLAGS_A, 8'h00);
    wr(`GPIO_OFS_CPU_FLAG, 8'h00);
    idle(2);
    chk({7'h00, irqPortA}, 8'h00);
    @(posedge core_clk);
    extA <= 8'h7B;
    idle(3);
    chk({7'h00, irqPortA}, 8'h00);
    rd(`GPIO_OFS_FLAGS_A, 1'b0, 8'h20);
    wr(`GPIO_OFS_FLAGS_A, 8'h00);
    wr(`GPIO_OFS_EDGE, 8'h01);
    extA <= 8'h7A;
    idle(3);
    rd(`GPIO_OFS_FLAGS_A, 1'b0, 8'h01);
    chk({7'h00, irqPortA}, 8'h01);
    wr(`GPIO_OFS_FLAGS_A, 8'h00);
    wr(`GPIO_OFS_CPU_FLAG, 8'h00);
    extB <= 8'h08;
    idle(3);
    chk({7'h00, irqPortB}, 8'h00);
    @(posedge core_clk);
    extB <= 8'h0C;
    idle(3);
    chk({7'h00, irqPortB}, 8'h01);
    rd(`GPIO_OFS_FLAGS_B, 1'b0, 8'h0C);
    wr(`GPIO_OFS_FLAGS_B, 8'h00);
    wr(`GPIO_OFS_CPU_FLAG, 8'h00);
    wr(`GPIO_OFS_SUBEN, 8'h04);
    extC <= 5'h00;
    idle(2);
    @(posedge core_clk);
    extC <= 5'h10;
    idle(3);
    chk({7'h00, irqPortC}, 8'h01);
    wr(`GPIO_OFS_CPU_EN, 8'h03);
    idle(2);
    chk({7'h00, irqPortC}, 8'h00);
    wr(`GPIO_OFS_FLAGS_C, 8'h00);
    wr(`GPIO_OFS_CPU_FLAG, 8'h00);
    $display("interrupt test done");
    for (int i = 0; i < 2; i++)
    begin
      wr(`GPIO_OFS_DIR_A, 8'hFF);
      wr(`GPIO_OFS_PORT_A, 8'h0F);
      idle(2);
      @(posedge core_clk);
      powerMode <= (i == 0) ? PWR_DEEP2 : PWR_DEEP3;
      wr(`GPIO_OFS_PORT_A, 8'hF0);
      wr(`GPIO_OFS_DIR_A, 8'h00);
      idle(2);
      chk(padAOut, 8'h0F);
      chk(padAOeN, 8'h00);
      @(posedge core_clk);
      powerMode <= PWR_ACTIVE;
      idle(2);
      chk(padAOeN, 8'hFF);
    end
    $display("deep sleep test done");
    complete_run();
  end
endmodule
`default_nettype wire
